/* File: rtl/obl_pkg.sv */
// constants and helpers shared by the output boolean logic block
// assumes a single 40 MHz clock and plain configuration ports
//
// Summary of operation
// - each output follows host level or its own boolean logic, per config.
// - logic result is the OR of at most two AND terms.
// - term inputs come from outputs 0..7, general inputs, rail flags.
// - each term picks one rail-status type, then any subset of rails.
// - sticky status types hold until maker clear command or clear input.
// - delay can apply on assertion, deassertion, both or neither.
// - outputs 0..7 give their internal logic state for sequencing use.
// - power-good excludes rails without an enabled voltage monitor.
// - normal delay mode filters changes shorter than the delay.
// - ignore mode latches a trigger and applies it when delay expires.
// - in ignore mode a pulse lasts at least the delay of its ending edge, when that delay is enabled.
// - state machine mode uses term 0 while true, term 1 while false.
// - at most one general input serves each selected function (clear, margin enable, margin direction).
// - with fault enable set, input deassertion flags a fault.
// - the selected clear input clears all sticky rail flags.
// - margin enable input places margining rails in margined state.
// - margin direction input asserted means low, deasserted means high.
// - each general input polarity is active low or active high.
// - first three defined general inputs drive pin-picked rail states.

package obl_pkg;

    // -------------------------------------------------------------
    // sizes
    // -------------------------------------------------------------
    localparam int NO = 10;       // general outputs
    localparam int NG = 8;        // general inputs
    localparam int NR = 10;       // rails
    localparam int NT = 8;        // live rail-status types
    localparam int NTERM = 2;     // and terms per output
    localparam int NDEP = 8;      // outputs usable as term inputs
    localparam int NPICK = 3;     // inputs used for pin-picked states
    localparam int DW = 16;       // delay counter width
    localparam int SYNC_N = 3;    // input synchroniser depth

    // -------------------------------------------------------------
    // field layouts
    // -------------------------------------------------------------
    localparam int SELW = 4;        // special function select width
    localparam int SEL_EN_BIT = 3;  // select valid flag
    localparam int SEL_IDX_W = 3;   // input index field
    localparam int TYPW = 4;        // term status type width
    localparam int TYP_LATCH_BIT = 3;
    localparam int TYP_IDX_W = 3;
    localparam logic [TYP_IDX_W-1:0] TYPE_PG = 3'h0;

    typedef logic [DW-1:0] obl_cnt_t;

    // one-of-eight input pick, zero when the function is unassigned
    function automatic logic obl_gsel(input logic [NG-1:0] v,
                                      input logic [SELW-1:0] s);
        return s[SEL_EN_BIT] & v[s[SEL_IDX_W-1:0]];
    endfunction

endpackage

/* File: rtl/obl_delay.sv */
// one output's assertion/deassertion delay stage
// assumes din_i and all settings come from logic on clk_i
`timescale 1ns/100ps

module obl_delay
    import obl_pkg::*;
(
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic din_i,
    input wire logic ign_i,
    input wire logic dly_asrt_i,
    input wire logic dly_deas_i,
    input wire obl_cnt_t cnt_asrt_i,
    input wire obl_cnt_t cnt_deas_i,
    output logic q_o
);

    logic q_r;
    logic busy_r;
    logic tgt_r;
    obl_cnt_t cnt_r;
    logic want;
    logic den;
    obl_cnt_t lim;

    // -------------------------------------------------------------
    // direction decode
    // -------------------------------------------------------------
    // while ignoring, the captured target wins over the live input
    always_comb
    begin
        want = (ign_i && busy_r) ? tgt_r : din_i;
        den = want ? dly_asrt_i : dly_deas_i;
        lim = want ? cnt_asrt_i : cnt_deas_i;
    end

    // tick counter; outside ignore mode a return to q before expiry drops the change
    always_ff @(posedge clk_i)
    begin
        if (!nrst_i)
        begin
            q_r <= 1'b0;
            busy_r <= 1'b0;
            tgt_r <= 1'b0;
            cnt_r <= '0;
        end
        else if (want == q_r)
        begin
            busy_r <= 1'b0;
            cnt_r <= '0;
        end
        else if (!den || lim == '0 || cnt_r == lim - obl_cnt_t'(1))
        begin
            q_r <= want;
            busy_r <= 1'b0;
            cnt_r <= '0;
        end
        else
        begin
            busy_r <= 1'b1;
            tgt_r <= want;
            cnt_r <= cnt_r + obl_cnt_t'(1);
        end
    end

    assign q_o = q_r;

    // -------------------------------------------------------------
    // checks
    // -------------------------------------------------------------
    logic prev_r;
    obl_cnt_t run_r;

    // cycles since q last changed, saturating
    always_ff @(posedge clk_i)
    begin
        if (!nrst_i)
        begin
            prev_r <= 1'b0;
            run_r <= '0;
        end
        else
        begin
            prev_r <= q_r;
            if (q_r != prev_r)
                run_r <= obl_cnt_t'(1);
            else if (run_r != '1)
                run_r <= run_r + obl_cnt_t'(1);
        end
    end

    default clocking @(posedge clk_i); endclocking
    default disable iff (!nrst_i);

    // a four-cycle pulse from rest, shorter than the assertion delay
    sequence short_hi_s;
        (!ign_i && !din_i && !q_o) ##1
        (!ign_i && dly_asrt_i && cnt_asrt_i > 4 && din_i)[*4]
        ##1 !din_i;
    endsequence

    no_delay_a: assert property (
        !dly_asrt_i && !ign_i && din_i && !q_o |=> q_o)
        else $error("undelayed assertion not immediate");

    glitch_filt_a: assert property (
        short_hi_s |=> !q_o)
        else $error("short pulse passed the filter");

    ignore_hold_a: assert property (
        ign_i && busy_r && $past(busy_r) |-> $stable(tgt_r))
        else $error("target changed while ignoring input");

    min_width_a: assert property (
        ign_i && dly_deas_i && $stable(cnt_deas_i) && $fell(q_o)
        |-> run_r >= cnt_deas_i)
        else $error("pulse shorter than deassert delay");

endmodule

/* File: rtl/obl_output_logic.sv */
// general output boolean logic, delays and input special functions
// assumes config ports are static software settings on clk_i,
// rail flags come from logic on clk_i, general input pins are async
`timescale 1ns/100ps

module obl_output_logic
    import obl_pkg::*;
(
    input wire logic clk_i,
    input wire logic nrst_i,
    // general input pins and their setup
    input wire logic [NG-1:0] gpi_pin_i,
    input wire logic [NG-1:0] gpi_act_high_i,
    input wire logic [NG-1:0] gpi_fault_en_i,
    input wire logic [NG-1:0] gpi_defined_i,
    input wire logic [SELW-1:0] clr_src_sel_i,
    input wire logic [SELW-1:0] mrg_en_sel_i,
    input wire logic [SELW-1:0] mrg_dir_sel_i,
    // host clear of sticky flags, one-cycle pulse
    input wire logic maker_specific_clr_i,
    // live rail flags, type-major, and monitor presence
    input wire logic [NT*NR-1:0] rail_stat_i,
    input wire logic [NR-1:0] rail_mon_on_i,
    // direct host drive
    input wire logic [NO-1:0] host_ctl_i,
    input wire logic [NO-1:0] host_lvl_i,
    // term setup, index (output*NTERM + term)
    input wire logic [NO*NTERM*NDEP-1:0] t_gpo_mask_i,
    input wire logic [NO*NTERM*NG-1:0] t_gpi_mask_i,
    input wire logic [NO*NTERM*NR-1:0] t_rail_mask_i,
    input wire logic [NO*NTERM*TYPW-1:0] t_type_i,
    input wire logic [NO*NTERM-1:0] t_en_i,
    // per-output mode and delay setup
    input wire logic [NO-1:0] sm_mode_i,
    input wire logic [NO-1:0] ign_dly_i,
    input wire logic [NO-1:0] dly_asrt_en_i,
    input wire logic [NO-1:0] dly_deas_en_i,
    input wire logic [NO*DW-1:0] dly_asrt_cnt_i,
    input wire logic [NO*DW-1:0] dly_deas_cnt_i,
    // results
    output logic [NO-1:0] general_output_o,
    output logic [NDEP-1:0] dep_state_o,
    output logic [NG-1:0] gpi_fault_o,
    output logic margin_on_o,
    output logic margin_direction_low_o,
    output logic [NPICK-1:0] pin_pick_o,
    output logic [NT*NR-1:0] latch_stat_o
);

    // -------------------------------------------------------------
    // general input synchroniser
    // -------------------------------------------------------------
    logic [NG-1:0] s1_r;
    logic [NG-1:0] s2_r;
    logic [NG-1:0] s3_r;
    logic [NG-1:0] gst_r;
    logic [NG-1:0] gact;
    logic [NG-1:0] gact_q_r;

    // three stages; level only moves once stages two and three agree
    always_ff @(posedge clk_i)
    begin
        if (!nrst_i)
        begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            gst_r <= '0;
        end
        else
        begin
            s1_r <= gpi_pin_i;
            s2_r <= s1_r;
            s3_r <= s2_r;
            gst_r <= (s2_r & s3_r) | (gst_r & (s2_r ^ s3_r));
        end
    end

    // logical level after polarity
    assign gact = ~(gst_r ^ gpi_act_high_i);

    // previous level, for clear-source edge detect; starts high so an
    // active-low input settling after reset never looks like a clear edge
    always_ff @(posedge clk_i)
    begin
        if (!nrst_i)
            gact_q_r <= '1;
        else
            gact_q_r <= gact;
    end

    // -------------------------------------------------------------
    // sticky rail flags
    // -------------------------------------------------------------
    logic gpi_clr;
    logic clr_w;
    logic [NT*NR-1:0] lat_r;

    // one index per function, so no two pins can share a function
    assign gpi_clr = obl_gsel(gact, clr_src_sel_i) &
                     ~obl_gsel(gact_q_r, clr_src_sel_i);
    assign clr_w = gpi_clr | maker_specific_clr_i;

    // a flag arriving with the clear survives it
    always_ff @(posedge clk_i)
    begin
        if (!nrst_i)
            lat_r <= '0;
        else if (clr_w)
            lat_r <= rail_stat_i;
        else
            lat_r <= lat_r | rail_stat_i;
    end

    assign latch_stat_o = lat_r;

    // -------------------------------------------------------------
    // and-term evaluation
    // -------------------------------------------------------------
    // empty mask bits leave an input out; a disabled term is false
    function automatic logic eval_term(
        input logic [NDEP-1:0] st,
        input logic [NG-1:0] ga,
        input logic [NT*NR-1:0] live,
        input logic [NT*NR-1:0] lat,
        input logic [NR-1:0] mon,
        input logic [NDEP-1:0] gm,
        input logic [NG-1:0] im,
        input logic [NR-1:0] rm,
        input logic [TYPW-1:0] typ,
        input logic en);
        logic [TYP_IDX_W-1:0] idx;
        logic [NR-1:0] fl;
        logic [NR-1:0] rsel;
        idx = typ[TYP_IDX_W-1:0];
        fl = typ[TYP_LATCH_BIT] ? lat[idx*NR +: NR]
                                : live[idx*NR +: NR];
        rsel = rm;
        if (idx == TYPE_PG)
            rsel = rm & mon;
        return en & (&(~gm | st)) & (&(~im | ga))
                  & (&(~rsel | fl));
    endfunction

    logic [NO-1:0] st;
    logic [NO-1:0] res;
    logic [NO*NTERM-1:0] tv;

    // sum of products, or path select in state machine mode
    always_comb
    begin
        res = '0;
        tv = '0;
        for (int o = 0; o < NO; o++)
        begin
            for (int k = 0; k < NTERM; k++)
            begin
                tv[o*NTERM+k] = eval_term(st[NDEP-1:0], gact,
                    rail_stat_i, lat_r, rail_mon_on_i,
                    t_gpo_mask_i[(o*NTERM+k)*NDEP +: NDEP],
                    t_gpi_mask_i[(o*NTERM+k)*NG +: NG],
                    t_rail_mask_i[(o*NTERM+k)*NR +: NR],
                    t_type_i[(o*NTERM+k)*TYPW +: TYPW],
                    t_en_i[o*NTERM+k]);
            end
            if (sm_mode_i[o])
                res[o] = st[o] ? tv[o*NTERM]
                               : tv[o*NTERM+1];
            else
                res[o] = tv[o*NTERM] | tv[o*NTERM+1];
        end
    end

    // -------------------------------------------------------------
    // per-output delay stages
    // -------------------------------------------------------------
    // the stage output is the logic state that terms and deps see
    for (genvar g = 0; g < NO; g++)
    begin : g_dly
        obl_delay u_dly (
            .clk_i(clk_i),
            .nrst_i(nrst_i),
            .din_i(res[g]),
            .ign_i(ign_dly_i[g]),
            .dly_asrt_i(dly_asrt_en_i[g]),
            .dly_deas_i(dly_deas_en_i[g]),
            .cnt_asrt_i(dly_asrt_cnt_i[g*DW +: DW]),
            .cnt_deas_i(dly_deas_cnt_i[g*DW +: DW]),
            .q_o(st[g])
        );
    end

    // -------------------------------------------------------------
    // output pins
    // -------------------------------------------------------------
    logic [NO-1:0] gout_r;

    // host drive overrides logic, pin-for-pin
    always_ff @(posedge clk_i)
    begin
        if (!nrst_i)
            gout_r <= '0;
        else
            gout_r <= (host_ctl_i & host_lvl_i) |
                      (~host_ctl_i & st);
    end

    assign general_output_o = gout_r;
    // internal state, not the pin, so host drive never leaks in
    assign dep_state_o = st[NDEP-1:0];

    // -------------------------------------------------------------
    // input special functions
    // -------------------------------------------------------------
    logic [NG-1:0] fault_r;
    logic mon_r;
    logic mdir_r;
    logic [NPICK-1:0] pick_r;
    logic [NPICK-1:0] pick_nxt;

    // fault is a level while the input stays deasserted
    always_ff @(posedge clk_i)
    begin
        if (!nrst_i)
            fault_r <= '0;
        else
            fault_r <= gpi_fault_en_i & ~gact;
    end

    // direction only counts while margining is on
    always_ff @(posedge clk_i)
    begin
        if (!nrst_i)
        begin
            mon_r <= 1'b0;
            mdir_r <= 1'b0;
        end
        else
        begin
            mon_r <= obl_gsel(gact, mrg_en_sel_i);
            mdir_r <= obl_gsel(gact, mrg_en_sel_i) &
                      obl_gsel(gact, mrg_dir_sel_i);
        end
    end

    // first defined inputs in index order, whatever their purpose
    always_comb
    begin
        int n;
        n = 0;
        pick_nxt = '0;
        for (int i = 0; i < NG; i++)
        begin
            if (gpi_defined_i[i] && n < NPICK)
            begin
                pick_nxt[n] = gact[i];
                n = n + 1;
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!nrst_i)
            pick_r <= '0;
        else
            pick_r <= pick_nxt;
    end

    assign gpi_fault_o = fault_r;
    assign margin_on_o = mon_r;
    assign margin_direction_low_o = mdir_r;
    assign pin_pick_o = pick_r;

    // -------------------------------------------------------------
    // checks
    // -------------------------------------------------------------
    logic mdir_lvl;

    // selected direction level, so the check can look one cycle back
    assign mdir_lvl = obl_gsel(gact, mrg_dir_sel_i);

    default clocking @(posedge clk_i); endclocking
    default disable iff (!nrst_i);

    sequence pin_low_fault_s;
        (gpi_fault_en_i[0] && gpi_act_high_i[0] && !gpi_pin_i[0])[*6];
    endsequence

    sequence pin_hi_inv_s;
        (gpi_pin_i[0] && !gpi_act_high_i[0])[*5];
    endsequence

    host_drive_a: assert property (
        1 |=> ((general_output_o ^ $past(host_lvl_i))
               & $past(host_ctl_i)) == '0)
        else $error("host level not driven on pin");

    logic_drive_a: assert property (
        !host_ctl_i[0] |=> general_output_o[0] == $past(dep_state_o[0]))
        else $error("logic state not driven on pin");

    sm_path_a: assert property (
        sm_mode_i[0] && st[0] && !tv[0] |-> !res[0])
        else $error("state machine ignored path 0");

    sticky_hold_a: assert property (
        !clr_w |=> (lat_r & $past(lat_r)) == $past(lat_r))
        else $error("sticky flag dropped without clear");

    latch_clear_a: assert property (
        clr_w && rail_stat_i == '0 |=> lat_r == '0)
        else $error("sticky flags not cleared");

    // watched on term 4, the first term of output 2
    pg_exclude_a: assert property (
        t_en_i[4] && t_type_i[4*TYPW +: TYPW] == TYPW'(TYPE_PG) &&
        t_gpo_mask_i[4*NDEP +: NDEP] == '0 &&
        (t_gpi_mask_i[4*NG +: NG] & ~gact) == '0 &&
        (t_rail_mask_i[4*NR +: NR] & rail_mon_on_i) == '0 |-> tv[4])
        else $error("unmonitored rail used in logic");

    polarity_a: assert property (
        pin_hi_inv_s |-> !gact[0])
        else $error("active low input read as asserted");

    gpi_fault_a: assert property (
        pin_low_fault_s |-> gpi_fault_o[0])
        else $error("deasserted input not flagged");

    margin_on_a: assert property (
        obl_gsel(gact, mrg_en_sel_i) |=> margin_on_o)
        else $error("margin enable not followed");

    margin_dir_a: assert property (
        margin_on_o |-> margin_direction_low_o == $past(mdir_lvl))
        else $error("margin direction wrong");

    pin_pick_a: assert property (
        &gpi_defined_i[NPICK-1:0] |=>
        pin_pick_o == $past(gact[NPICK-1:0]))
        else $error("pin pick bits not first inputs");

endmodule

/* File: sim/obl_ext_side.sv */
// far-side model: external system signals wired to the general inputs
// assumes the bench asks for pin levels; pins are async to the clock
`timescale 1ns/100ps

module obl_ext_side
    import obl_pkg::*;
(
    input wire logic [NG-1:0] lvl_i,
    output logic [NG-1:0] pin_o
);
    // -------------------------------------------------------------
    // pin drivers
    // -------------------------------------------------------------
    // board skew keeps pin edges clear of the sampling clock edge;
    // the system always drives these pins, so there is no idle float
    assign #3 pin_o = lvl_i;
endmodule

/* File: sim/output_boolean_logic_test.sv */
// self-checking bench for the output boolean logic block
// assumes obl_pkg sizes; every input is driven on the falling edge
`timescale 1ns/100ps

module output_boolean_logic_test
    import obl_pkg::*;
;
    // -------------------------------------------------------------
    // stimulus and observation
    // -------------------------------------------------------------
    typedef struct packed {
        logic [7:0] pin;
        logic [7:0] ah;
        logic [7:0] flt;
        logic mon;
        logic mdl;
        logic [2:0] pick;
    } obl_row_s;

    // defined inputs 1,4,5 feed the pick; margin on input 2, dir on 3
    obl_row_s rows [6] = '{
        '{8'h00, 8'h00, 8'h00, 1'b1, 1'b1, 3'h7},
        '{8'hff, 8'h00, 8'h0f, 1'b0, 1'b0, 3'h0},
        '{8'h04, 8'hff, 8'h0b, 1'b1, 1'b0, 3'h0},
        '{8'h0c, 8'h0f, 8'h03, 1'b1, 1'b1, 3'h6},
        '{8'h32, 8'hff, 8'h0d, 1'b0, 1'b0, 3'h7},
        '{8'h08, 8'h00, 8'h08, 1'b1, 1'b0, 3'h7}};

    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [NG-1:0] pin_lvl = '0;
    logic [NG-1:0] act_hi = '0;
    logic [NG-1:0] fen = 8'h0f;
    logic [NG-1:0] gdef = 8'hf2;
    logic [SELW-1:0] clr_sel = 4'hf;
    logic [SELW-1:0] men_sel = 4'ha;
    logic [SELW-1:0] mdir_sel = 4'hb;
    logic mclr = 1'b0;
    logic [NT*NR-1:0] rstat = '0;
    logic [NR-1:0] mon = 10'h3ff;
    logic [NO-1:0] hctl = 10'h3fa;
    logic [NO-1:0] hlvl = '0;
    logic [NO*NTERM*NDEP-1:0] gmask = '0;
    logic [NO*NTERM*NG-1:0] imask = 160'h1_0000_0001;
    logic [NO*NTERM*NR-1:0] rmask = 200'h100_0000_1000;
    logic [NO*NTERM*TYPW-1:0] typ = 80'h90;
    logic [NO*NTERM-1:0] ten = 20'h13;
    logic [NO-1:0] smm = '0;
    logic [NO-1:0] ign = '0;
    logic [NO-1:0] dae = '0;
    logic [NO-1:0] dde = '0;
    logic [NO*DW-1:0] acnt = '0;
    logic [NO*DW-1:0] dcnt = '0;
    logic [NG-1:0] gpi_pin;
    logic [NO-1:0] gout;
    logic [NDEP-1:0] dep;
    logic [NG-1:0] flt;
    logic mon_on;
    logic mdl;
    logic [NPICK-1:0] pick;
    logic [NT*NR-1:0] lat;
    int miscompares = 0;
    int compares = 0;
    int cyc = 0;
    int hi;

    obl_ext_side ext (.lvl_i(pin_lvl), .pin_o(gpi_pin));

    obl_output_logic dut (
        .clk_i(clk), .nrst_i(nrst), .gpi_pin_i(gpi_pin),
        .gpi_act_high_i(act_hi), .gpi_fault_en_i(fen),
        .gpi_defined_i(gdef), .clr_src_sel_i(clr_sel),
        .mrg_en_sel_i(men_sel), .mrg_dir_sel_i(mdir_sel),
        .maker_specific_clr_i(mclr), .rail_stat_i(rstat),
        .rail_mon_on_i(mon), .host_ctl_i(hctl), .host_lvl_i(hlvl),
        .t_gpo_mask_i(gmask), .t_gpi_mask_i(imask),
        .t_rail_mask_i(rmask), .t_type_i(typ), .t_en_i(ten),
        .sm_mode_i(smm), .ign_dly_i(ign), .dly_asrt_en_i(dae),
        .dly_deas_en_i(dde), .dly_asrt_cnt_i(acnt),
        .dly_deas_cnt_i(dcnt), .general_output_o(gout),
        .dep_state_o(dep), .gpi_fault_o(flt), .margin_on_o(mon_on),
        .margin_direction_low_o(mdl), .pin_pick_o(pick),
        .latch_stat_o(lat));

    // -------------------------------------------------------------
    // clock, watchdog and helpers
    // -------------------------------------------------------------
    initial
    begin
        forever #12.5 clk = ~clk;
    end

    // whole run is about 300 cycles; a hang stops well past that
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            miscompares++;
            summarize();
        end
    end

    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic chk(input string nm, input logic [79:0] e,
                       input logic [79:0] g);
        compares++;
        if (g !== e)
        begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    // input 0 high for n cycles, counts output 0 high cycles over n+40 cycles from the rise
    task automatic pulse(input int n, output int h);
        h = 0;
        pin_lvl[0] = 1'b1;
        for (int c = 0; c < n + 40; c++)
        begin
            if (c == n)
                pin_lvl[0] = 1'b0;
            @(negedge clk);
            if (gout[0] === 1'b1)
                h++;
        end
    endtask

    task automatic summarize();
        if (miscompares == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // -------------------------------------------------------------
    // main sequence
    // -------------------------------------------------------------
    initial
    begin
        tick(20);
        chk("out_rst", '0, gout);
        chk("lat_rst", '0, lat);
        nrst = 1'b1;
        tick(2);
        // ordinary cases: pin levels and polarity per row
        foreach (rows[i])
        begin
            pin_lvl = rows[i].pin;
            act_hi = rows[i].ah;
            tick(8);
            chk("fault", rows[i].flt, flt);
            chk("margin_on", rows[i].mon, mon_on);
            chk("margin_low", rows[i].mdl, mdl);
            chk("pin_pick", rows[i].pick, pick);
        end
        act_hi = '1;
        pin_lvl = '0;
        hlvl = 10'h2aa;
        tick(8);
        chk("host_out", 10'h2aa, gout & 10'h3fa);
        hlvl = 10'h155;
        tick(3);
        chk("host_flip", 10'h150, gout & 10'h3fa);
        // logic outputs; output 2 ands input 0 with rail 0 good
        pin_lvl[0] = 1'b1;
        tick(8);
        chk("out0_and", 1'b1, gout[0]);
        chk("dep0", 1'b1, dep[0]);
        gdef = 8'h07;
        tick(2);
        chk("pick_first", 3'h1, pick);
        chk("out2_pg", 1'b0, gout[2]);
        mon[0] = 1'b0;
        tick(4);
        chk("out2_nomon", 1'b1, gout[2]);
        pin_lvl[0] = 1'b0;
        tick(8);
        chk("out0_low", 1'b0, gout[0]);
        // sticky flag from a one-cycle live pulse, two ways to clear
        for (int k = 0; k < 2; k++)
        begin
            rstat[12] = 1'b1;
            tick(1);
            rstat[12] = 1'b0;
            tick(4);
            chk("lat_set", 1'b1, lat[12]);
            chk("out0_lat", 1'b1, gout[0]);
            if (k == 0)
                mclr = 1'b1;
            else
                pin_lvl[7] = 1'b1;
            tick(1);
            mclr = 1'b0;
            tick(7);
            chk("lat_clr", 1'b0, lat[12]);
            pin_lvl[7] = 1'b0;
            tick(6);
        end
        // delay of 8 ticks both ways on output 0
        acnt[15:0] = 16'h0008;
        dcnt[15:0] = 16'h0008;
        dae[0] = 1'b1;
        dde[0] = 1'b1;
        tick(4);
        pulse(4, hi);
        chk("glitch", '0, hi);
        pin_lvl[0] = 1'b1;
        tick(8);
        chk("asrt_wait", 1'b0, gout[0]);
        tick(8);
        chk("asrt_done", 1'b1, gout[0]);
        pin_lvl[0] = 1'b0;
        tick(8);
        chk("deas_wait", 1'b1, gout[0]);
        tick(8);
        chk("deas_done", 1'b0, gout[0]);
        ign[0] = 1'b1;
        pulse(3, hi);
        chk("ign_fire", 1'b1, hi >= 8);
        // state machine: term 0 is input 1, term 1 is input 0
        ign[0] = 1'b0;
        dae[0] = 1'b0;
        dde[0] = 1'b0;
        smm[0] = 1'b1;
        imask[15:0] = 16'h0102;
        typ[7:4] = 4'h0;
        rmask[19:10] = '0;
        pin_lvl[1] = 1'b1;
        tick(8);
        chk("sm_idle", 1'b0, gout[0]);
        pin_lvl[0] = 1'b1;
        tick(8);
        chk("sm_set", 1'b1, gout[0]);
        pin_lvl[0] = 1'b0;
        tick(8);
        chk("sm_hold", 1'b1, gout[0]);
        pin_lvl[1] = 1'b0;
        tick(8);
        chk("sm_drop", 1'b0, gout[0]);
        summarize();
    end
endmodule
